// ### sre_defines.vh
// Purpose: constants of the string repeat engine
// Assumes: Avalon-MM word addressing, one 32-bit register per word
// Notes:   included by sre_string_engine.v, its property module and the bench
`ifndef SRE_DEFINES_VH
`define SRE_DEFINES_VH

// ----------------------------------------
// register word indices
// ----------------------------------------
`define SRE_REG_CMD     4'h0
`define SRE_REG_STATUS  4'h1
`define SRE_REG_FLAGS   4'h2
`define SRE_REG_SRC     4'h3
`define SRE_REG_DST     4'h4
`define SRE_REG_CNT     4'h5
`define SRE_REG_ACC     4'h6
`define SRE_REG_PORT    4'h7
`define SRE_REG_LOWER   4'h8
`define SRE_REG_UPPER   4'h9

// ----------------------------------------
// operations, sizes, prefixes, segments
// ----------------------------------------
`define SRE_OP_COPY     5'h00
`define SRE_OP_COMPARE  5'h01
`define SRE_OP_SEARCH   5'h02
`define SRE_OP_FETCH    5'h03
`define SRE_OP_FILL     5'h04
`define SRE_OP_PIN      5'h05
`define SRE_OP_POUT     5'h06
`define SRE_OP_INS      5'h07
`define SRE_OP_MEMORY_TO_PORT_OP     5'h08
`define SRE_OP_DSET     5'h09
`define SRE_OP_DCLR     5'h0a
`define SRE_OP_CSET     5'h0b
`define SRE_OP_CCLR     5'h0c
`define SRE_OP_CINV     5'h0d
`define SRE_OP_OVTRAP   5'h0e
`define SRE_OP_RANGE    5'h0f
`define SRE_OP_SOFT     5'h10
`define SRE_SZ_BYTE     2'h0
`define SRE_SZ_WORD     2'h1
`define SRE_SZ_DWORD    2'h2
`define SRE_PFX_NONE    2'h0
`define SRE_PFX_REP     2'h1
`define SRE_PFX_EQ      2'h2
`define SRE_PFX_NE      2'h3
`define SRE_SEG_ES      3'h0
`define SRE_SEG_DS      3'h3

// ----------------------------------------
// flags word bit positions, vectors
// ----------------------------------------
`define SRE_FB_CF       0
`define SRE_FB_PF       2
`define SRE_FB_AF       4
`define SRE_FB_ZF       6
`define SRE_FB_SF       7
`define SRE_FB_DF       10
`define SRE_FB_OF       11
`define SRE_VEC_OVF     8'h04
`define SRE_VEC_RANGE   8'h05
`define SRE_RST_WORD    32'h00000000

`endif

// ### sre_mem_model.sv
// Purpose: memory and port partner of the string engine
// Assumes: one request at a time, answered by a one-cycle memAck
// Notes:   latency alternates; port read returns number ^ c3c3c3c3
`timescale 1ns/1ns
module sre_mem_model (
  input  logic        core_clk,
  input  logic        rst,
  input  logic        memReq,
  input  logic        memWrite,
  input  logic        memIo,
  input  logic [31:0] memAddr,
  input  logic [31:0] memWdata,
  input  logic [1:0]  memSize,
  output logic [31:0] memRdata,
  output logic        memAck
);
  logic [7:0]  mem [0:255];
  logic [31:0] portOut;
  logic [7:0]  lastPort;
  logic [1:0]  delay;
  logic        slow;
  logic        served;
  logic [7:0]  a;
  assign a = memAddr[7:0];
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h96;
  // ----------------------------------------
  // request service
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      memAck   <= 1'b0;
      memRdata <= 32'h0;
      delay    <= 2'h0;
      slow     <= 1'b0;
      served   <= 1'b0;
      portOut  <= 32'h0;
      lastPort <= 8'h0;
    end else if (memAck) begin
      memAck   <= 1'b0;
      memRdata <= ~memRdata; // data gone once the answer is taken
    end else if (!memReq) begin
      served   <= 1'b0;
      memRdata <= ~memRdata;
    end else if (!served && delay != 2'h0) begin
      delay <= delay - 2'h1;
    end else if (!served) begin
      memAck <= 1'b1;
      served <= 1'b1;
      slow   <= ~slow;
      delay  <= slow ? 2'h0 : 2'h2;
      if (memIo && memWrite) begin
        portOut  <= memWdata;
        lastPort <= a;
      end else if (memIo) begin
        memRdata <= memAddr ^ 32'hc3c3c3c3;
      end else if (memWrite) begin
        mem[a] <= memWdata[7:0];
        if (memSize != 2'h0) mem[a + 8'h1] <= memWdata[15:8];
        if (memSize[1]) mem[a + 8'h2] <= memWdata[23:16];
        if (memSize[1]) mem[a + 8'h3] <= memWdata[31:24];
      end else begin
        memRdata <= {mem[a + 8'h3], mem[a + 8'h2], mem[a + 8'h1], mem[a]};
      end
    end
  end
endmodule

// ### sre_string_engine.v
// Purpose: string element, port, flag and trap command engine
// Assumes: memory/port partner on core_clk, answers a request with memAck
// Notes:   software loads registers, then a command word write starts work
`timescale 1ns/1ns
`include "sre_defines.vh"

module sre_string_engine (
  input  wire        core_clk,
  input  wire        rst,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg         memReq,
  output reg         memWrite,
  output reg         memIo,
  output reg  [2:0]  memSeg,
  output reg  [31:0] memAddr,
  output reg  [31:0] memWdata,
  output reg  [1:0]  memSize,
  input  wire [31:0] memRdata,
  input  wire        memAck,
  output reg         trapReq,
  output reg  [7:0]  trapVector
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_CHECK = 3'h1;
  localparam [2:0] ST_SRC   = 3'h2;
  localparam [2:0] ST_DST   = 3'h3;
  localparam [2:0] ST_WR    = 3'h4;
  localparam [2:0] ST_WAIT  = 3'h5;
  localparam [2:0] ST_STEP  = 3'h6;

  reg [2:0]  state;
  reg [1:0]  phase;
  reg [4:0]  op;
  reg [1:0]  size;
  reg [1:0]  prefix;
  reg [2:0]  srcSeg;
  reg        useImm;
  reg [7:0]  immField;
  reg [31:0] source_index;
  reg [31:0] dest_index;
  reg [31:0] count_reg;
  reg [31:0] accumulator;
  reg [31:0] port_select_reg;
  reg [31:0] lowerBound;
  reg [31:0] upperBound;
  reg [31:0] srcData;
  reg [31:0] dstData;
  reg        carry_flag;
  reg        parity_flag;
  reg        aux_carry_flag;
  reg        zero_flag;
  reg        sign_flag;
  reg        direction_flag;
  reg        overflow_flag;
  reg        trapSeen;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [31:0] sizeMask;
    input [1:0] sz;
    begin
      case (sz)
        `SRE_SZ_BYTE: sizeMask = 32'h000000ff;
        `SRE_SZ_WORD: sizeMask = 32'h0000ffff;
        default:      sizeMask = 32'hffffffff;
      endcase
    end
  endfunction
  // {of, sf, zf, af, pf, cf} of a - b at element size
  function [5:0] subFlags;
    input [31:0] a;
    input [31:0] b;
    input [1:0]  sz;
    reg   [31:0] m;
    reg   [31:0] d;
    integer      t;
    begin
      m = sizeMask(sz);
      d = (a & m) - (b & m);
      t = (8 << sz) - 1;
      subFlags = {(a[t] != b[t]) && (d[t] != a[t]), d[t], (d & m) == 32'h0,
                  a[4] ^ b[4] ^ d[4], ~^d[7:0], (a & m) < (b & m)};
    end
  endfunction
  // one element up or down as the flag selects
  function [31:0] stepIdx;
    input [31:0] idx;
    input [1:0]  sz;
    input        down;
    begin
      stepIdx = down ? idx - (32'h1 << sz) : idx + (32'h1 << sz);
    end
  endfunction
  function [31:0] beMerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer i;
    begin
      beMerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) beMerge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction
  function usesSrc;
    input [4:0] o;
    begin
      usesSrc = (o == `SRE_OP_COPY) || (o == `SRE_OP_COMPARE) ||
                (o == `SRE_OP_FETCH) || (o == `SRE_OP_MEMORY_TO_PORT_OP);
    end
  endfunction
  function usesDst;
    input [4:0] o;
    begin
      usesDst = (o == `SRE_OP_COPY) || (o == `SRE_OP_COMPARE) ||
                (o == `SRE_OP_SEARCH) || (o == `SRE_OP_FILL) || (o == `SRE_OP_INS);
    end
  endfunction

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire [31:0] mask     = sizeMask(size);
  wire        portRd   = (op == `SRE_OP_PIN) || (op == `SRE_OP_INS);
  wire        portWr   = (op == `SRE_OP_POUT) || (op == `SRE_OP_MEMORY_TO_PORT_OP);
  wire        needRd1  = usesSrc(op) || portRd;
  wire        needRd2  = (op == `SRE_OP_COMPARE) || (op == `SRE_OP_SEARCH);
  wire        needWr   = (op == `SRE_OP_COPY) || (op == `SRE_OP_FILL) ||
                         (op == `SRE_OP_INS) || portWr;
  wire        isString = usesSrc(op) || usesDst(op);
  wire        repeated = isString && (prefix != `SRE_PFX_NONE);
  wire [31:0] portNum  = ((op == `SRE_OP_PIN) || (op == `SRE_OP_POUT)) && useImm ?
                         {24'h0, immField} : {16'h0, port_select_reg[15:0]};
  wire [31:0] cmpLeft  = (op == `SRE_OP_SEARCH) ? accumulator : srcData;
  wire [5:0]  newFlags = subFlags(cmpLeft, dstData, size);
  wire [31:0] cntLess  = count_reg - 32'h1;
  wire [31:0] wrData   = (op == `SRE_OP_FILL) || (op == `SRE_OP_POUT) ?
                         accumulator & mask : srcData;
  wire        cmdWr    = avs_write && !avs_waitrequest &&
                         (avs_address == `SRE_REG_CMD) && (state == ST_IDLE);
  wire        regWr    = avs_write && !avs_waitrequest && (state == ST_IDLE);
  wire [31:0] cmdWord  = avs_writedata;
  wire        outBelow = $signed(accumulator) < $signed(lowerBound);
  wire        outAbove = $signed(accumulator) > $signed(upperBound);

  // termination test after an iteration, zero flag only for compare/search
  wire        zfStop   = needRd2 && (((prefix == `SRE_PFX_EQ) && !newFlags[3]) ||
                                     ((prefix == `SRE_PFX_NE) && newFlags[3]));

  wire [31:0] flagsWord = (carry_flag << `SRE_FB_CF) | (parity_flag << `SRE_FB_PF) |
                          (aux_carry_flag << `SRE_FB_AF) | (zero_flag << `SRE_FB_ZF) |
                          (sign_flag << `SRE_FB_SF) | (direction_flag << `SRE_FB_DF) |
                          (overflow_flag << `SRE_FB_OF);

  reg [31:0] rdMux;
  always @* begin
    case (avs_address)
      `SRE_REG_CMD:    rdMux = {8'h0, immField, 2'h0, useImm, 1'b0, srcSeg,
                                prefix, size, op};
      `SRE_REG_STATUS: rdMux = {16'h0, trapVector, 6'h0, trapSeen, state != ST_IDLE};
      `SRE_REG_FLAGS:  rdMux = flagsWord;
      `SRE_REG_SRC:    rdMux = source_index;
      `SRE_REG_DST:    rdMux = dest_index;
      `SRE_REG_CNT:    rdMux = count_reg;
      `SRE_REG_ACC:    rdMux = accumulator;
      `SRE_REG_PORT:   rdMux = port_select_reg;
      `SRE_REG_LOWER:  rdMux = lowerBound;
      `SRE_REG_UPPER:  rdMux = upperBound;
      default:         rdMux = 32'h0;
    endcase
  end

  // ----------------------------------------
  // bus slave: one wait cycle per access
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= `SRE_RST_WORD;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= rdMux;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ----------------------------------------
  // engine
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      phase <= 2'h0;
      {op, size, prefix} <= {`SRE_OP_COPY, `SRE_SZ_BYTE, `SRE_PFX_NONE};
      srcSeg <= `SRE_SEG_DS;
      {useImm, immField} <= 9'h0;
      {source_index, dest_index, count_reg, accumulator} <= {4{`SRE_RST_WORD}};
      {port_select_reg, lowerBound, upperBound} <= {3{`SRE_RST_WORD}};
      {srcData, dstData} <= {2{`SRE_RST_WORD}};
      {carry_flag, parity_flag, aux_carry_flag, zero_flag} <= 4'h0;
      {sign_flag, direction_flag, overflow_flag, trapSeen} <= 4'h0;
      {memReq, memWrite, memIo, trapReq} <= 4'h0;
      memSeg <= `SRE_SEG_DS;
      {memAddr, memWdata} <= {2{`SRE_RST_WORD}};
      memSize <= `SRE_SZ_BYTE;
      trapVector <= 8'h0;
    end else begin
      trapReq <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (regWr) begin
            case (avs_address)
              `SRE_REG_FLAGS: begin
                carry_flag <= avs_writedata[`SRE_FB_CF];
                parity_flag <= avs_writedata[`SRE_FB_PF];
                aux_carry_flag <= avs_writedata[`SRE_FB_AF];
                zero_flag <= avs_writedata[`SRE_FB_ZF];
                sign_flag <= avs_writedata[`SRE_FB_SF];
                direction_flag <= avs_writedata[`SRE_FB_DF];
                overflow_flag <= avs_writedata[`SRE_FB_OF];
              end
              `SRE_REG_SRC:   source_index <= beMerge(source_index, avs_writedata, avs_byteenable);
              `SRE_REG_DST:   dest_index <= beMerge(dest_index, avs_writedata, avs_byteenable);
              `SRE_REG_CNT:   count_reg <= beMerge(count_reg, avs_writedata, avs_byteenable);
              `SRE_REG_ACC:   accumulator <= beMerge(accumulator, avs_writedata, avs_byteenable);
              `SRE_REG_PORT:  port_select_reg <= beMerge(port_select_reg, avs_writedata,
                                                         avs_byteenable);
              `SRE_REG_LOWER: lowerBound <= beMerge(lowerBound, avs_writedata, avs_byteenable);
              `SRE_REG_UPPER: upperBound <= beMerge(upperBound, avs_writedata, avs_byteenable);
              default: ;
            endcase
          end
          if (cmdWr) begin
            op <= cmdWord[4:0];
            size <= (cmdWord[6:5] == 2'h3) ? `SRE_SZ_DWORD : cmdWord[6:5];
            prefix <= cmdWord[8:7];
            srcSeg <= cmdWord[12] ? cmdWord[11:9] : `SRE_SEG_DS;
            useImm <= cmdWord[13];
            immField <= cmdWord[23:16];
            trapSeen <= 1'b0;
            case (cmdWord[4:0])
              `SRE_OP_DSET: direction_flag <= 1'b1;
              `SRE_OP_DCLR: direction_flag <= 1'b0;
              `SRE_OP_CSET: carry_flag <= 1'b1;
              `SRE_OP_CCLR: carry_flag <= 1'b0;
              `SRE_OP_CINV: carry_flag <= ~carry_flag;
              `SRE_OP_OVTRAP: begin
                if (overflow_flag) begin
                  trapReq <= 1'b1;
                  trapVector <= `SRE_VEC_OVF;
                  trapSeen <= 1'b1;
                end
              end
              `SRE_OP_RANGE: begin
                if (outBelow || outAbove) begin
                  trapReq <= 1'b1;
                  trapVector <= `SRE_VEC_RANGE;
                  trapSeen <= 1'b1;
                end
              end
              `SRE_OP_SOFT: begin
                trapReq <= 1'b1;
                trapVector <= cmdWord[23:16];
                trapSeen <= 1'b1;
              end
              default: begin
                if (cmdWord[4:0] <= `SRE_OP_MEMORY_TO_PORT_OP) state <= ST_CHECK;
              end
            endcase
          end
        end
        // with a prefix on a string op, zero count skips even the first element
        ST_CHECK: state <= (repeated && count_reg == 32'h0) ? ST_IDLE : ST_SRC;
        ST_SRC: begin
          if (needRd1) begin
            {memReq, memWrite} <= 2'h2;
            memIo <= portRd;
            memAddr <= portRd ? portNum : source_index;
            memSeg <= srcSeg;
            memSize <= size;
            phase <= 2'h0;
            state <= ST_WAIT;
          end else begin
            state <= ST_DST;
          end
        end
        ST_DST: begin
          if (needRd2) begin
            {memReq, memWrite, memIo} <= 3'h4;
            memAddr <= dest_index;
            memSeg <= `SRE_SEG_ES;
            memSize <= size;
            phase <= 2'h1;
            state <= ST_WAIT;
          end else begin
            state <= ST_WR;
          end
        end
        ST_WR: begin
          // compare and search never write back
          if (needWr) begin
            {memReq, memWrite} <= 2'h3;
            memIo <= portWr;
            memAddr <= portWr ? portNum : dest_index;
            memSeg <= `SRE_SEG_ES;
            memWdata <= wrData;
            memSize <= size;
            phase <= 2'h2;
            state <= ST_WAIT;
          end else begin
            state <= ST_STEP;
          end
        end
        ST_WAIT: begin
          if (memAck) begin
            {memReq, memWrite} <= 2'h0;
            case (phase)
              2'h0: begin
                srcData <= memRdata & mask;
                state <= ST_DST;
              end
              2'h1: begin
                dstData <= memRdata & mask;
                state <= ST_WR;
              end
              default: state <= ST_STEP;
            endcase
          end
        end
        ST_STEP: begin
          if (needRd2) begin
            {overflow_flag, sign_flag, zero_flag} <= newFlags[5:3];
            {aux_carry_flag, parity_flag, carry_flag} <= newFlags[2:0];
          end
          if (op == `SRE_OP_PIN || op == `SRE_OP_FETCH) begin
            accumulator <= (accumulator & ~mask) | (srcData & mask);
          end
          if (usesSrc(op)) source_index <= stepIdx(source_index, size, direction_flag);
          if (usesDst(op)) dest_index <= stepIdx(dest_index, size, direction_flag);
          if (repeated) count_reg <= cntLess;
          if (repeated && !zfStop) state <= ST_CHECK;
          else state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

// ### sre_string_engine_properties.sv
// Purpose: concurrent checks on the string engine ports
// Assumes: single core_clk domain, rst async active high
// Notes:   bound to every sre_string_engine instance
`timescale 1ns/1ns
`include "sre_defines.vh"
module sre_string_engine_props (
  input logic        core_clk,
  input logic        rst,
  input logic [3:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_writedata,
  input logic        avs_waitrequest,
  input logic        memReq,
  input logic        memWrite,
  input logic        memIo,
  input logic [2:0]  memSeg,
  input logic [31:0] memAddr,
  input logic [31:0] memWdata,
  input logic [1:0]  memSize,
  input logic        memAck,
  input logic        trapReq,
  input logic [7:0]  trapVector
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic cmdDone;
  assign cmdDone = avs_write && !avs_waitrequest && avs_address == `SRE_REG_CMD;

  AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered after one wait cycle");
  AST_BUS_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_REQ_HOLD: assert property (memReq && !memAck |=> memReq && $stable(memAddr)
    && $stable(memSeg) && $stable(memWrite) && $stable(memWdata))
    else $error("memory request changed before acknowledge");
  AST_REQ_DROP: assert property (memReq && memAck |=> ##[0:1] !memReq)
    else $error("memory request not released after acknowledge");
  AST_DST_SEG: assert property (memReq && memWrite && !memIo |-> memSeg == `SRE_SEG_ES)
    else $error("destination write not in extra segment");
  AST_ELEM_BYTE: assert property (memReq && memWrite && memSize == `SRE_SZ_BYTE
    |-> memWdata[31:8] == 24'h0)
    else $error("byte element carries upper bits");
  AST_ELEM_WORD: assert property (memReq && memWrite && memSize == `SRE_SZ_WORD
    |-> memWdata[31:16] == 16'h0)
    else $error("word element carries upper bits");
  AST_PORT_ZX: assert property (memReq && memIo |-> memAddr[31:16] == 16'h0)
    else $error("port number not zero extended");
  AST_FLAG_NOBUS: assert property (cmdDone && avs_writedata[4:0] >= `SRE_OP_DSET
    |=> !memReq [*4])
    else $error("flag or trap command touched the bus");
  AST_TRAP_CAUSE: assert property (trapReq |-> $past(cmdDone) || $past(cmdDone, 2))
    else $error("trap without a command write");
  AST_TRAP_PULSE: assert property (trapReq |=> !trapReq)
    else $error("trap request longer than one cycle");
  AST_VEC_HOLD: assert property (!trapReq |=> $stable(trapVector) || trapReq)
    else $error("trap vector changed without a trap");

  cover property (memReq && memAck && memWrite && !memIo);
  cover property (memReq && memAck && memIo);
  cover property (trapReq);
endmodule

bind sre_string_engine sre_string_engine_props i_props (.core_clk, .rst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .memReq, .memWrite, .memIo,
  .memSeg, .memAddr, .memWdata, .memSize, .memAck, .trapReq, .trapVector);

// ### tb.sv
// Purpose: self-checking bench of the string engine
// Assumes: registers loaded over Avalon-MM, memory partner model on the far side
// Notes:   one task per scenario
`timescale 1ns/1ns
`include "sre_defines.vh"
module tb;
  logic        core_clk;
  logic        rst;
  logic [3:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic        memReq, memWrite, memIo, memAck, trapReq;
  logic [2:0]  memSeg, rdSeg;
  logic [31:0] memAddr, memWdata, memRdata;
  logic [1:0]  memSize;
  logic [7:0]  trapVector;
  int          fail_count, comparisons;
  int          trapCnt = 0;

  sre_string_engine i_sre_string_engine (.core_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .memReq, .memWrite, .memIo, .memSeg, .memAddr, .memWdata, .memSize, .memRdata,
    .memAck, .trapReq, .trapVector);
  sre_mem_model i_sre_mem_model (.core_clk, .rst, .memReq, .memWrite, .memIo, .memAddr,
    .memWdata, .memSize, .memRdata, .memAck);

  always @(posedge core_clk) if (trapReq === 1'b1) trapCnt <= trapCnt + 1;
  always @(posedge core_clk) if (memReq && memAck && !memWrite && !memIo) rdSeg <= memSeg;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] pb(input logic [7:0] a);
    pb = a ^ 8'h96;
  endfunction
  function automatic logic [31:0] mk(input logic [4:0] op, input logic [1:0] sz, pf);
    mk = {23'h0, pf, sz, op};
  endfunction
  function automatic logic [31:0] mb(input logic [7:0] a);
    mb = {24'h0, i_sre_mem_model.mem[a]};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, q, exp);
  endtask
  task automatic run(input logic [31:0] cmd);
    logic [31:0] q;
    wr(`SRE_REG_CMD, cmd);
    do bus(1'b0, `SRE_REG_STATUS, 32'h0, q); while (q[0] !== 1'b0);
  endtask

  task automatic t_flags;
    logic [4:0]  ops [6] = '{`SRE_OP_CSET, `SRE_OP_CINV, `SRE_OP_CINV, `SRE_OP_CCLR,
                             `SRE_OP_DSET, `SRE_OP_DCLR};
    logic [31:0] fw [6] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h400, 32'h0};
    wr(`SRE_REG_FLAGS, 32'h0);
    foreach (ops[i]) begin
      run(mk(ops[i], 2'h0, 2'h0));
      rdc("flags", `SRE_REG_FLAGS, fw[i]);
    end
    $display("flag test done");
  endtask
  task automatic t_copy;
    wr(`SRE_REG_SRC, 32'h10);
    wr(`SRE_REG_DST, 32'h40);
    wr(`SRE_REG_CNT, 32'h2);
    run(mk(`SRE_OP_COPY, `SRE_SZ_DWORD, `SRE_PFX_REP) | 32'h1a00);
    chk("dst0", mb(8'h40) | mb(8'h43) << 24, {pb(8'h13), 16'h0, pb(8'h10)});
    chk("dst1", mb(8'h47), {24'h0, pb(8'h17)});
    rdc("src", `SRE_REG_SRC, 32'h18);
    rdc("dst", `SRE_REG_DST, 32'h48);
    rdc("cnt", `SRE_REG_CNT, 32'h0);
    chk("srcseg", {29'h0, rdSeg}, 32'h5);
    wr(`SRE_REG_ACC, 32'hffffffff);
    wr(`SRE_REG_SRC, 32'h20);
    run(mk(`SRE_OP_FETCH, `SRE_SZ_WORD, `SRE_PFX_NONE));
    rdc("acc", `SRE_REG_ACC, {16'hffff, pb(8'h21), pb(8'h20)});
    rdc("src", `SRE_REG_SRC, 32'h22);
    chk("defseg", {29'h0, rdSeg}, {29'h0, `SRE_SEG_DS});
    $display("copy test done");
  endtask
  task automatic t_fill;
    run(mk(`SRE_OP_DSET, 2'h0, 2'h0));
    wr(`SRE_REG_ACC, 32'ha1b2c3d4);
    wr(`SRE_REG_DST, 32'h60);
    wr(`SRE_REG_CNT, 32'h0);
    run(mk(`SRE_OP_FILL, `SRE_SZ_BYTE, `SRE_PFX_REP));
    chk("skip", mb(8'h60), {24'h0, pb(8'h60)});
    rdc("dst", `SRE_REG_DST, 32'h60);
    wr(`SRE_REG_CNT, 32'h2);
    run(mk(`SRE_OP_FILL, `SRE_SZ_BYTE, `SRE_PFX_REP));
    chk("fill", mb(8'h5f) << 8 | mb(8'h60), 32'hd4d4);
    rdc("dst", `SRE_REG_DST, 32'h5e);
    rdc("cnt", `SRE_REG_CNT, 32'h0);
    run(mk(`SRE_OP_DCLR, 2'h0, 2'h0));
    $display("fill test done");
  endtask
  task automatic t_cmp;
    wr(`SRE_REG_FLAGS, 32'h0);
    i_sre_mem_model.mem[8'h91] = 8'h20;
    i_sre_mem_model.mem[8'h90] = pb(8'h80);
    wr(`SRE_REG_SRC, 32'h80);
    wr(`SRE_REG_DST, 32'h90);
    wr(`SRE_REG_CNT, 32'h3);
    run(mk(`SRE_OP_COMPARE, `SRE_SZ_BYTE, `SRE_PFX_EQ));
    rdc("cnt", `SRE_REG_CNT, 32'h1);
    rdc("src", `SRE_REG_SRC, 32'h82);
    rdc("flags", `SRE_REG_FLAGS, 32'h81);
    chk("nowrite", mb(8'h91), 32'h20);
    wr(`SRE_REG_ACC, 32'h12343534);
    wr(`SRE_REG_DST, 32'ha0);
    wr(`SRE_REG_CNT, 32'h4);
    run(mk(`SRE_OP_SEARCH, `SRE_SZ_WORD, `SRE_PFX_NE));
    rdc("cnt", `SRE_REG_CNT, 32'h2);
    rdc("dst", `SRE_REG_DST, 32'ha4);
    rdc("flags", `SRE_REG_FLAGS, 32'h44);
    rdc("acc", `SRE_REG_ACC, 32'h12343534);
    $display("compare test done");
  endtask
  task automatic t_port;
    wr(`SRE_REG_ACC, 32'h11223344);
    run(mk(`SRE_OP_PIN, `SRE_SZ_BYTE, `SRE_PFX_NONE) | 32'h005a2000);
    rdc("acc", `SRE_REG_ACC, 32'h11223399);
    wr(`SRE_REG_PORT, 32'h1234);
    run(mk(`SRE_OP_PIN, `SRE_SZ_DWORD, `SRE_PFX_NONE));
    rdc("acc", `SRE_REG_ACC, 32'hc3c3d1f7);
    run(mk(`SRE_OP_POUT, `SRE_SZ_WORD, `SRE_PFX_NONE));
    chk("pout", i_sre_mem_model.portOut, 32'hd1f7);
    wr(`SRE_REG_PORT, 32'h77);
    wr(`SRE_REG_SRC, 32'h10);
    wr(`SRE_REG_CNT, 32'h2);
    run(mk(`SRE_OP_MEMORY_TO_PORT_OP, `SRE_SZ_BYTE, `SRE_PFX_REP));
    chk("memory_to_port_op", i_sre_mem_model.portOut, {24'h0, pb(8'h11)});
    chk("port", {24'h0, i_sre_mem_model.lastPort}, 32'h77);
    rdc("src", `SRE_REG_SRC, 32'h12);
    wr(`SRE_REG_DST, 32'hc0);
    wr(`SRE_REG_CNT, 32'h1);
    run(mk(`SRE_OP_INS, `SRE_SZ_BYTE, `SRE_PFX_REP));
    chk("ins", mb(8'hc0), 32'hb4);
    rdc("dst", `SRE_REG_DST, 32'hc1);
    $display("port test done");
  endtask
  task automatic t_trap;
    int c;
    c = trapCnt;
    wr(`SRE_REG_FLAGS, 32'h0);
    run(mk(`SRE_OP_OVTRAP, 2'h0, 2'h0));
    chk("notrap", 32'(trapCnt - c), 32'h0);
    wr(`SRE_REG_FLAGS, 32'h800);
    run(mk(`SRE_OP_OVTRAP, 2'h0, 2'h0));
    chk("vec", {24'h0, trapVector}, {24'h0, `SRE_VEC_OVF});
    rdc("status", `SRE_REG_STATUS, 32'h402);
    wr(`SRE_REG_ACC, 32'hfffffffb);
    wr(`SRE_REG_LOWER, 32'hfffffffc);
    wr(`SRE_REG_UPPER, 32'ha);
    run(mk(`SRE_OP_RANGE, 2'h0, 2'h0));
    chk("vec", {24'h0, trapVector}, {24'h0, `SRE_VEC_RANGE});
    wr(`SRE_REG_ACC, 32'hfffffffc);
    run(mk(`SRE_OP_RANGE, 2'h0, 2'h0));
    wr(`SRE_REG_ACC, 32'hb);
    run(mk(`SRE_OP_RANGE, 2'h0, 2'h0));
    chk("ntrap", 32'(trapCnt - c), 32'h3);
    run(mk(`SRE_OP_SOFT, 2'h0, 2'h0) | 32'h00210000);
    chk("vec", {24'h0, trapVector}, 32'h21);
    $display("trap test done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    fail_count = 0;
    comparisons = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_flags;
    t_copy;
    t_fill;
    t_cmp;
    t_port;
    t_trap;
    wrap_up;
  end
  initial begin
    #200000;
    fail_count++;
    wrap_up;
  end
endmodule
